/* File: rtl/l1_cache_fill_and_broadcast.v */
// level-one instruction and data caches with fill-way report and op broadcast
// assumes an apb master, a core that holds each request until taken, and a
// system bus that grants an address tenure and then returns or takes beats
`include "l1_cache_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module l1_way_cache (
   input wire clk,
   input wire rstn,
   input wire req,
   input wire [31:0] addr,
   input wire we,
   input wire [63:0] wdata,
   input wire wt,
   input wire attr,
   input wire op_inval,
   input wire op_clean,
   input wire op_zero,
   output wire take,
   output reg rvalid,
   output reg [63:0] rdata,
   output wire op_done,
   output wire breq,
   output wire [2:0] bkind,
   output wire [31:0] baddr,
   output wire [63:0] bwdata,
   output reg battr,
   output wire bbusy,
   input wire bgnt,
   input wire bbeat,
   input wire [63:0] brdata,
   output reg [1:0] fway,
   output wire filling
);
   localparam S_IDLE = 3'h0, S_WB = 3'h1, S_FILL = 3'h2, S_WTS = 3'h3, S_ZERO = 3'h4, S_DONE = 3'h5;
   reg [2:0] state;
   reg [19:0] tags [0:511];
   reg [511:0] vld;
   reg [511:0] dty;
   reg [7:0] lru [0:127];
   reg [63:0] mem [0:2047];
   reg [31:0] maddr;
   reg [63:0] mdata;
   reg mwe, mop, oi, oz, pend, bact, crit;
   reg [1:0] beat;
   reg [3:0] hv;
   reg [1:0] hw, vw;
   reg fnd;
   reg [7:0] age;
   integer i, j;
   wire [6:0] set = addr[11:5];
   wire [6:0] mset = maddr[11:5];
   wire [1:0] dwi = maddr[4:3] + beat;
   wire hit = |hv;
   wire opreq = op_inval | op_clean | op_zero;
   function [7:0] touch(input [7:0] a, input [1:0] w);
      integer k;
      reg [1:0] aw;
      begin
         aw = a[w*2 +: 2];
         touch = a;
         for (k = 0; k < 4; k = k + 1) begin
            if (k == w)
               touch[k*2 +: 2] = 2'h0;
            else if (a[k*2 +: 2] < aw)
               touch[k*2 +: 2] = a[k*2 +: 2] + 2'h1;
         end
      end
   endfunction
   // ****************************************
   // lookup and victim choice
   // ****************************************
   always @* begin
      age = lru[set];
      fnd = 1'b0;
      vw = 2'h0;
      for (i = 0; i < 4; i = i + 1)
         hv[i] = vld[{i[1:0], set}] && (tags[{i[1:0], set}] == addr[31:12]);
      hw = hv[3] ? 2'h3 : hv[2] ? 2'h2 : hv[1] ? 2'h1 : 2'h0;
      for (i = 0; i < 4; i = i + 1) begin
         if (!vld[{i[1:0], set}] && !fnd) begin
            vw = i[1:0];
            fnd = 1'b1;
         end
      end
      for (i = 0; i < 4; i = i + 1) begin
         if (!fnd && age[i*2 +: 2] == 2'h3)
            vw = i[1:0];
      end
   end
   // reads may hit in other lines once the critical word is in
   wire look_ok = (state == S_IDLE && !opreq) || (state == S_FILL && crit && !we);
   wire crit_fwd = state == S_FILL && bact && bbeat && beat == 2'h0 && !mwe && req;
   assign take = (look_ok && req && hit) || crit_fwd;
   assign op_done = state == S_DONE;
   assign breq = pend;
   assign bbusy = pend | bact;
   assign filling = state == S_FILL;
   assign bkind = state == S_WB ? `K_WLINE : state == S_WTS ? `K_WSINGLE : `K_READ;
   assign baddr = state == S_WB ? {tags[{fway, mset}], mset, 5'h00} : {maddr[31:3], 3'h0};
   assign bwdata = state == S_WB ? mem[{fway, mset, beat}] : mdata;
   // ****************************************
   // control and arrays
   // ****************************************
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= S_IDLE;
         vld <= 512'h0;
         dty <= 512'h0;
         maddr <= 32'h00000000;
         mdata <= 64'h0;
         mwe <= 1'b0;
         mop <= 1'b0;
         oi <= 1'b0;
         oz <= 1'b0;
         pend <= 1'b0;
         bact <= 1'b0;
         crit <= 1'b0;
         beat <= 2'h0;
         rvalid <= 1'b0;
         rdata <= 64'h0;
         battr <= 1'b0;
         fway <= 2'h0;
         for (j = 0; j < 128; j = j + 1)
            lru[j] <= `LRU_RST;
      end else begin
         rvalid <= take;
         if (crit_fwd)
            rdata <= brdata;
         else if (take && !we)
            rdata <= mem[{hw, set, addr[4:3]}];
         if (take && !crit_fwd)
            lru[set] <= touch(lru[set], hw);
         if (pend && bgnt) begin
            pend <= 1'b0;
            bact <= 1'b1;
         end
         case (state)
            S_IDLE: begin
               if (opreq) begin
                  maddr <= addr;
                  mop <= 1'b1;
                  oi <= op_inval;
                  oz <= op_zero;
                  beat <= 2'h0;
                  fway <= hit ? hw : vw;
                  if (op_zero && !hit && vld[{vw, set}] && dty[{vw, set}]) begin
                     state <= S_WB;
                     pend <= 1'b1;
                  end else if (op_zero)
                     state <= S_ZERO;
                  else if (hit && op_clean && dty[{hw, set}]) begin
                     state <= S_WB;
                     pend <= 1'b1;
                  end else begin
                     if (hit && op_inval) begin
                        vld[{hw, set}] <= 1'b0;
                        dty[{hw, set}] <= 1'b0;
                     end
                     state <= S_DONE;
                  end
               end else if (req && hit) begin
                  if (we) begin
                     mem[{hw, set, addr[4:3]}] <= wdata;
                     if (!wt)
                        dty[{hw, set}] <= 1'b1;
                     else begin
                        maddr <= addr;
                        mdata <= wdata;
                        pend <= 1'b1;
                        state <= S_WTS;
                     end
                  end
               end else if (req) begin
                  maddr <= addr;
                  mwe <= we;
                  mop <= 1'b0;
                  battr <= attr;
                  fway <= vw;
                  vld[{vw, set}] <= 1'b0;
                  beat <= 2'h0;
                  crit <= 1'b0;
                  pend <= 1'b1;
                  state <= (vld[{vw, set}] && dty[{vw, set}]) ? S_WB : S_FILL;
               end
            end
            S_WB: begin
               if (bact && bbeat) begin
                  beat <= beat + 2'h1;
                  if (beat == 2'h3) begin
                     bact <= 1'b0;
                     dty[{fway, mset}] <= 1'b0;
                     if (!mop) begin
                        pend <= 1'b1;
                        state <= S_FILL;
                     end else if (oz)
                        state <= S_ZERO;
                     else begin
                        if (oi)
                           vld[{fway, mset}] <= 1'b0;
                        state <= S_DONE;
                     end
                  end
               end
            end
            S_FILL: begin
               if (bact && bbeat) begin
                  mem[{fway, mset, dwi}] <= brdata;
                  beat <= beat + 2'h1;
                  if (beat == 2'h0)
                     crit <= 1'b1;
                  if (beat == 2'h3) begin
                     bact <= 1'b0;
                     crit <= 1'b0;
                     tags[{fway, mset}] <= maddr[31:12];
                     vld[{fway, mset}] <= 1'b1;
                     dty[{fway, mset}] <= 1'b0;
                     lru[mset] <= touch(lru[mset], fway);
                     state <= S_IDLE;
                  end
               end
            end
            S_WTS: begin
               if (bact && bbeat) begin
                  bact <= 1'b0;
                  state <= S_IDLE;
               end
            end
            S_ZERO: begin
               mem[{fway, mset, beat}] <= 64'h0;
               beat <= beat + 2'h1;
               if (beat == 2'h3) begin
                  tags[{fway, mset}] <= maddr[31:12];
                  vld[{fway, mset}] <= 1'b1;
                  dty[{fway, mset}] <= 1'b1;
                  state <= S_DONE;
               end
            end
            S_DONE: begin
               if (!opreq) begin
                  mop <= 1'b0;
                  state <= S_IDLE;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule // l1_way_cache

module l1_cache_fill_and_broadcast (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire ifetch_req,
   input wire [31:0] ifetch_addr,
   input wire ifetch_coherent,
   output wire ifetch_take,
   output wire ifetch_valid,
   output wire [63:0] ifetch_data,
   input wire dreq,
   input wire [31:0] daddr,
   input wire dwe,
   input wire [63:0] dwdata,
   input wire dwt,
   input wire dcoherent,
   output wire dtake,
   output wire dvalid,
   output wire [63:0] drdata,
   input wire cop_valid,
   input wire [2:0] cop_code,
   input wire [31:0] cop_addr,
   output wire cop_done,
   output reg cop_refused,
   output wire bus_req,
   output wire [2:0] bus_kind,
   output wire [31:0] bus_addr,
   output wire [63:0] bus_wdata,
   output wire bus_global,
   input wire bus_gnt,
   input wire bus_beat,
   input wire [63:0] bus_rdata,
   output wire [1:0] fill_way_select
);
   localparam T_IDLE = 2'h0, T_LOCAL = 2'h1, T_BC = 2'h2, T_END = 2'h3;
   reg bus_broadcast_enable, fetch_coherence_enable;
   reg [1:0] tstate, own;
   reg [2:0] tcode;
   reg [31:0] taddr;
   wire i_breq, i_busy, i_battr, i_fill, i_done, d_breq, d_busy, d_battr, d_fill, d_done;
   wire [2:0] i_kind, d_kind;
   wire [31:0] i_addr, d_addr;
   wire [63:0] i_wd, d_wd;
   wire [1:0] i_fway, d_fway;
   wire loc = tstate == T_LOCAL;
   wire bc_req = tstate == T_BC;
   wire bcast = tcode == `OP_DCBI || tcode == `OP_DCBF || tcode == `OP_DCBST;
   // ****************************************
   // apb registers
   // ****************************************
   wire acc = psel && penable;
   wire hit_cfg = paddr == `CFG_OFF;
   wire hit_stat = paddr == `STAT_OFF;
   assign pready = 1'b1;
   assign pslverr = acc && !hit_cfg && !hit_stat;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_broadcast_enable <= 1'b0;
         fetch_coherence_enable <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         if (acc && pwrite && hit_cfg) begin
            bus_broadcast_enable <= pwdata[`BBE_BIT];
            fetch_coherence_enable <= pwdata[`FCE_BIT];
         end
         if (psel && !penable) begin
            prdata <= 32'h00000000;
            if (hit_cfg) begin
               prdata[`BBE_BIT] <= bus_broadcast_enable;
               prdata[`FCE_BIT] <= fetch_coherence_enable;
            end else if (hit_stat)
               prdata[6:0] <= {tstate, own, fill_way_select, i_busy | d_busy};
         end
      end
   end
   // ****************************************
   // cache-control operation sequencing
   // ****************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tstate <= T_IDLE;
         tcode <= 3'h0;
         taddr <= 32'h00000000;
         cop_refused <= 1'b0;
      end else begin
         case (tstate)
            T_IDLE: begin
               if (cop_valid) begin
                  tcode <= cop_code;
                  taddr <= cop_addr;
                  cop_refused <= 1'b0;
                  if (cop_code == `OP_DCBZ || (bus_broadcast_enable && cop_code < `OP_DCBZ))
                     tstate <= T_LOCAL;
                  else begin
                     cop_refused <= 1'b1;
                     tstate <= T_END;
                  end
               end
            end
            T_LOCAL: begin
               if (i_done || d_done)
                  tstate <= (bcast && bus_broadcast_enable) ? T_BC : T_END;
            end
            T_BC: begin
               if (own == 2'h3 && bus_gnt)
                  tstate <= T_END;
            end
            T_END: begin
               if (!cop_valid)
                  tstate <= T_IDLE;
            end
            default: tstate <= T_IDLE;
         endcase
      end
   end
   assign cop_done = tstate == T_END;
   // ****************************************
   // caches
   // ****************************************
   wire i_op = loc && tcode == `OP_ICBI;
   wire d_op = loc && tcode != `OP_ICBI;
   l1_way_cache icache (
      .clk(pclk), .rstn(presetn), .req(ifetch_req && !loc), .addr(i_op ? taddr : ifetch_addr),
      .we(1'b0), .wdata(64'h0), .wt(1'b0),
      .attr(ifetch_coherent && fetch_coherence_enable),
      .op_inval(i_op), .op_clean(1'b0), .op_zero(1'b0),
      .take(ifetch_take), .rvalid(ifetch_valid), .rdata(ifetch_data), .op_done(i_done),
      .breq(i_breq), .bkind(i_kind), .baddr(i_addr), .bwdata(i_wd), .battr(i_battr), .bbusy(i_busy),
      .bgnt(bus_gnt && own == 2'h2), .bbeat(bus_beat && own == 2'h2), .brdata(bus_rdata),
      .fway(i_fway), .filling(i_fill)
   );
   l1_way_cache dcache (
      .clk(pclk), .rstn(presetn), .req(dreq && !loc), .addr(d_op ? taddr : daddr),
      .we(dwe), .wdata(dwdata), .wt(dwt), .attr(dcoherent),
      .op_inval(d_op && (tcode == `OP_DCBI || tcode == `OP_DCBF)),
      .op_clean(d_op && (tcode == `OP_DCBF || tcode == `OP_DCBST)),
      .op_zero(d_op && tcode == `OP_DCBZ),
      .take(dtake), .rvalid(dvalid), .rdata(drdata), .op_done(d_done),
      .breq(d_breq), .bkind(d_kind), .baddr(d_addr), .bwdata(d_wd), .battr(d_battr), .bbusy(d_busy),
      .bgnt(bus_gnt && own == 2'h1), .bbeat(bus_beat && own == 2'h1), .brdata(bus_rdata),
      .fway(d_fway), .filling(d_fill)
   );
   // ****************************************
   // bus ownership; data side first since stores stall the core hardest
   // ****************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         own <= 2'h0;
      else if (own == 2'h0)
         own <= d_breq ? 2'h1 : i_breq ? 2'h2 : bc_req ? 2'h3 : 2'h0;
      else if ((own == 2'h1 && !d_busy) || (own == 2'h2 && !i_busy) || (own == 2'h3 && bus_gnt))
         own <= 2'h0;
   end
   wire [2:0] bc_kind = tcode == `OP_DCBI ? `K_INVAL : tcode == `OP_DCBF ? `K_FLUSH : `K_STORE;
   assign bus_req = own == 2'h1 ? d_breq : own == 2'h2 ? i_breq : own == 2'h3 ? bc_req : 1'b0;
   assign bus_kind = own == 2'h2 ? i_kind : own == 2'h3 ? bc_kind : d_kind;
   assign bus_addr = own == 2'h2 ? i_addr : own == 2'h3 ? {taddr[31:5], 5'h00} : d_addr;
   assign bus_wdata = own == 2'h2 ? i_wd : d_wd;
   assign bus_global = own == 2'h2 ? i_battr : own == 2'h3 ? 1'b1 : d_battr;
   assign fill_way_select = (own == 2'h1 && d_fill) ? d_fway : (own == 2'h2 && i_fill) ? i_fway : 2'h0;
endmodule // l1_cache_fill_and_broadcast
`default_nettype wire

/* File: shared/l1_cache_defs.vh */
// constants for the level-one cache fill and broadcast block
// assumes a 32-bit apb register port and 32-byte lines of four double words
`ifndef L1_CACHE_DEFS_VH
`define L1_CACHE_DEFS_VH
// ****************************************
// register map
// ****************************************
`define CFG_OFF 32'h00000000
`define STAT_OFF 32'h00000004
`define CFG_RST 32'h00000000
`define BBE_BIT 28
`define FCE_BIT 24
// ****************************************
// cache-control operation codes
// ****************************************
`define OP_ICBI 3'h0
`define OP_DCBI 3'h1
`define OP_DCBF 3'h2
`define OP_DCBST 3'h3
`define OP_DCBZ 3'h4
// ****************************************
// bus transaction kinds
// ****************************************
`define K_READ 3'h0
`define K_WLINE 3'h1
`define K_WSINGLE 3'h2
`define K_FLUSH 3'h3
`define K_INVAL 3'h4
`define K_STORE 3'h5
// ****************************************
// array reset values
// ****************************************
`define LRU_RST 8'he4
`endif

/* File: sim/l1_cache_chk_asserts.sv */
// assertion checker for the cache fill and broadcast block, top ports only
// assumes the constant header is on the include path; bound at the foot
`include "l1_cache_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module l1_cache_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic ifetch_req,
   input wire logic ifetch_coherent,
   input wire logic ifetch_take,
   input wire logic ifetch_valid,
   input wire logic [63:0] ifetch_data,
   input wire logic dreq,
   input wire logic cop_valid,
   input wire logic [2:0] cop_code,
   input wire logic cop_done,
   input wire logic cop_refused,
   input wire logic bus_req,
   input wire logic [2:0] bus_kind,
   input wire logic bus_global,
   input wire logic bus_gnt,
   input wire logic bus_beat,
   input wire logic [63:0] bus_rdata,
   input wire logic [1:0] fill_way_select
);
   logic bbe;
   logic fce;
   logic [2:0] nb;
   logic [1:0] cap;
   wire first = bus_beat && nb == 3'h0 && bus_kind == `K_READ;
   // ****************************************
   // mirror of the enable bits and beat count
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bbe <= 1'h0;
         fce <= 1'h0;
         nb <= 3'h0;
         cap <= 2'h0;
      end else begin
         if (psel && penable && pwrite && paddr == `CFG_OFF) begin
            bbe <= pwdata[`BBE_BIT];
            fce <= pwdata[`FCE_BIT];
         end
         if (bus_gnt)
            nb <= 3'h0;
         else if (bus_beat)
            nb <= nb + 3'h1;
         if (first)
            cap <= fill_way_select;
      end
   end
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_FILL_WAY_HELD:
      assert property (bus_beat && bus_kind == `K_READ && nb != 3'h0 |-> fill_way_select == cap)
      else $error("fill way moved within one fill");
   AST_ICRIT_FWD:
      assert property (ifetch_take && first && !dreq |=> ifetch_valid && ifetch_data == $past(bus_rdata))
      else $error("critical dword not forwarded");
   AST_IFETCH_PAIR:
      assert property (ifetch_take |=> ifetch_valid)
      else $error("fetch pair missing after take");
   AST_BCAST_ATTR:
      assert property (bus_req && bus_kind inside {`K_FLUSH, `K_INVAL, `K_STORE} |-> bus_global && bbe && cop_valid)
      else $error("bad broadcast tenure");
   AST_BCAST_DONE:
      assert property ($rose(cop_done) && !cop_refused && bbe && cop_code inside {`OP_DCBI, `OP_DCBF, `OP_DCBST}
         |-> $past(bus_gnt))
      else $error("op finished without broadcast");
   AST_OP_REFUSED:
      assert property ($rose(cop_done) && !bbe && cop_code != `OP_DCBZ |-> cop_refused)
      else $error("op ran with broadcast off");
   AST_ZERO_RUNS:
      assert property ($rose(cop_done) && cop_code == `OP_DCBZ |-> !cop_refused)
      else $error("zero op refused");
   AST_FETCH_COH:
      assert property (bus_gnt && bus_kind == `K_READ && ifetch_req && !dreq && fce |-> bus_global == ifetch_coherent)
      else $error("fetch coherence attribute wrong");
   cover property (ifetch_take && first);
   cover property (bus_gnt && bus_kind == `K_INVAL);
   cover property ($rose(cop_done) && cop_refused);
   cover property (ifetch_take && bus_beat && nb != 3'h0);
endmodule // l1_cache_chk
bind l1_cache_fill_and_broadcast l1_cache_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .ifetch_req, .ifetch_coherent, .ifetch_take, .ifetch_valid, .ifetch_data, .dreq, .cop_valid, .cop_code,
   .cop_done, .cop_refused, .bus_req, .bus_kind, .bus_global, .bus_gnt, .bus_beat, .bus_rdata, .fill_way_select);
`default_nettype wire

/* File: sim/sys_bus_model.sv */
// system bus model: grants tenures, returns read beats, keeps written beats
// assumes the block holds its request until granted; one tenure at a time
`include "l1_cache_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module sys_bus_model #(parameter int GAP = 2) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic req,
   input wire logic [2:0] kind,
   input wire logic [31:0] addr,
   input wire logic [63:0] wdata,
   output logic gnt,
   output logic beat,
   output logic [63:0] rdata
);
   logic [63:0] mem [logic [31:0]];
   initial begin : run
      logic [2:0] k;
      logic [31:0] a;
      logic [31:0] da;
      int n;
      gnt = 1'h0;
      beat = 1'h0;
      rdata = 64'h0;
      forever begin
         @(negedge clk);
         if (rstn && req) begin
            repeat ($urandom_range(3)) @(negedge clk);
            k = kind;
            a = addr;
            @(posedge clk);
            gnt <= 1'h1;
            @(posedge clk);
            gnt <= 1'h0;
            // address-only tenures end at the grant; lines wrap from the critical dword
            for (n = 0; n < (k == `K_WSINGLE ? 1 : k > `K_WSINGLE ? 0 : 4); n++) begin
               repeat ((n > 0) + $urandom_range(GAP)) @(posedge clk);
               da = {a[31:5], a[4:3] + n[1:0], 3'h0};
               beat <= 1'h1;
               rdata <= mem.exists(da) ? mem[da] : {~da, da};
               @(negedge clk);
               if (k != `K_READ)
                  mem[da] = wdata;
               @(posedge clk);
               beat <= 1'h0;
               // released data must not look like a held value
               rdata <= ~rdata;
            end
         end
      end
   end
endmodule // sys_bus_model
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench for the cache fill and broadcast block
// assumes the bus model and checker are compiled first
`include "l1_cache_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, ifetch_addr = 32'h0, daddr = 32'h0, cop_addr = 32'h0;
   logic ifetch_req = 1'h0, ifetch_coherent = 1'h0, dreq = 1'h0, dwe = 1'h0, dwt = 1'h0, dcoherent = 1'h0;
   logic cop_valid = 1'h0, cd = 1'h0;
   logic [63:0] dwdata = 64'h0, dv;
   logic [2:0] cop_code = 3'h0;
   wire [31:0] prdata, bus_addr;
   wire [63:0] ifetch_data, drdata, bus_wdata, bus_rdata;
   wire [2:0] bus_kind;
   wire [1:0] fill_way_select;
   wire pready, pslverr, ifetch_take, ifetch_valid, dtake, dvalid, cop_done, cop_refused, bus_req, bus_global;
   wire bus_gnt, bus_beat;
   int failures = 0, checks_done = 0, cyc = 0, nb = 0, k;
   logic [64:0] qd[$];
   logic [63:0] qp[$], qi[$], qw[$], qs[$], qk[$], qc[$], qg[$];
   localparam logic [31:0] ENB = (32'h1 << `BBE_BIT) | (32'h1 << `FCE_BIT);
   l1_cache_fill_and_broadcast dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .ifetch_req, .ifetch_addr, .ifetch_coherent, .ifetch_take, .ifetch_valid, .ifetch_data,
      .dreq, .daddr, .dwe, .dwdata, .dwt, .dcoherent, .dtake, .dvalid, .drdata, .cop_valid, .cop_code, .cop_addr,
      .cop_done, .cop_refused, .bus_req, .bus_kind, .bus_addr, .bus_wdata, .bus_global, .bus_gnt, .bus_beat,
      .bus_rdata, .fill_way_select);
   sys_bus_model #(.GAP(2)) bus_u (.clk(pclk), .rstn(presetn), .req(bus_req), .kind(bus_kind), .addr(bus_addr),
      .wdata(bus_wdata), .gnt(bus_gnt), .beat(bus_beat), .rdata(bus_rdata));
   initial forever #12.5 pclk = ~pclk;
   // ****************************************
   // checking and closing
   // ****************************************
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      if (failures == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   function automatic logic [63:0] pat(input logic [31:0] a);
      logic [31:0] d = {a[31:3], 3'h0};
      return {~d, d};
   endfunction
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         failures++;
         report_and_stop();
      end
   end
   // ****************************************
   // drivers
   // ****************************************
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [32:0] e);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      qp.push_back(e);
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic fetch(input logic [31:0] a, input logic c, input logic miss, input logic [1:0] w);
      @(posedge pclk);
      ifetch_req <= 1'h1;
      ifetch_addr <= a;
      ifetch_coherent <= c;
      qi.push_back(pat(a));
      if (miss) begin
         qw.push_back(w);
         qg.push_back(c);
      end
      do @(negedge pclk); while (ifetch_take !== 1'h1);
      @(posedge pclk);
      ifetch_req <= 1'h0;
   endtask
   task automatic dacc(input logic [31:0] a, input logic we, input logic wt, input logic [63:0] d,
      input logic [64:0] e);
      @(posedge pclk);
      dreq <= 1'h1;
      daddr <= a;
      dwe <= we;
      dwt <= wt;
      dwdata <= d;
      dcoherent <= $urandom;
      qd.push_back(e);
      do @(negedge pclk); while (dtake !== 1'h1);
      @(posedge pclk);
      dreq <= 1'h0;
   endtask
   task automatic cop(input logic [2:0] c, input logic [31:0] a, input logic r);
      @(posedge pclk);
      cop_valid <= 1'h1;
      cop_code <= c;
      cop_addr <= a;
      qc.push_back(r);
      do @(negedge pclk); while (cop_done !== 1'h1);
      @(posedge pclk);
      cop_valid <= 1'h0;
      do @(negedge pclk); while (cop_done !== 1'h0);
   endtask
   // ****************************************
   // monitor: oldest note against each result
   // ****************************************
   always @(negedge pclk) begin
      if (presetn) begin
         if (psel && penable && pready) chk({pslverr, pwrite ? 32'h0 : prdata}, qp.pop_front());
         if (ifetch_valid) chk(ifetch_data, qi.pop_front());
         if (dvalid && qd[0][64]) chk(drdata, qd[0][63:0]);
         if (dvalid) qd.delete(0);
         if (bus_gnt)
            nb = 0;
         if (bus_beat && bus_kind == `K_READ && nb == 0) chk(fill_way_select, qw.pop_front());
         if (bus_beat)
            nb++;
         if (bus_beat && bus_kind == `K_WSINGLE) chk(bus_wdata, qs.pop_front());
         if (bus_gnt && bus_kind > `K_WSINGLE) chk({bus_global, bus_kind}, qk.pop_front());
         if (bus_gnt && bus_kind == `K_READ && ifetch_req && !dreq) chk(bus_global, qg.pop_front());
         if (cop_done && !cd) chk(cop_refused, qc.pop_front());
         cd = cop_done;
      end
   end
   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      void'($urandom(53677));
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, `CFG_OFF, 32'h0, {1'h0, `CFG_RST});
      apb(1'h0, 32'h8, 32'h0, 33'h100000000);
      apb(1'h1, 32'h10, $urandom, 33'h100000000);
      // broadcast off: only the zero op may run; it leaves a dirty line
      for (k = 0; k < 8; k++) cop(k[2:0], 32'h8080, k != 4);
      apb(1'h1, `CFG_OFF, $urandom | ENB, 33'h0);
      apb(1'h0, `CFG_OFF, 32'h0, {1'h0, ENB});
      for (k = 3; k >= 0; k--) begin
         if (k > 0)
            qk.push_back({1'h1, k == 1 ? `K_INVAL : k == 2 ? `K_FLUSH : `K_STORE});
         cop(k[2:0], 32'h8080, 1'h0);
      end
      qw.push_back(2'h0);
      dacc(32'h8088, 1'h0, 1'h0, 64'h0, {1'h1, 64'h0});
      // six lines into one set: invalid ways first, then the oldest
      for (k = 0; k < 6; k++) fetch(32'h100040 + k * 32'h1000 + k[1:0] * 8, $urandom, 1'h1, k[1:0]);
      fetch(32'h300060, $urandom, 1'h1, 2'h0);
      fetch(32'h105058, $urandom, 1'h0, 2'h0);
      chk(nb < 4, 64'h1);
      dv = {$urandom, $urandom};
      qw.push_back(2'h0);
      dacc(32'h400020, 1'h0, 1'h0, 64'h0, {1'h1, pat(32'h400020)});
      dacc(32'h400020, 1'h1, 1'h0, dv, 65'h0);
      dacc(32'h400020, 1'h0, 1'h0, 64'h0, {1'h1, dv});
      qs.push_back(~dv);
      dacc(32'h400028, 1'h1, 1'h1, ~dv, 65'h0);
      dacc(32'h400028, 1'h0, 1'h0, 64'h0, {1'h1, ~dv});
      repeat (20) @(posedge pclk);
      report_and_stop();
   end
endmodule // tb_top
`default_nettype wire
